// ===== src/lmsp_pkg.sv
/*
  Constants, register map and carrier types for the LED matrix scan and PWM control block.
  Assumes a 10 MHz system clock and a byte-wide register port fed by a serial slave front end.
*/
package lmsp_pkg;

  // Matrix geometry
  localparam int unsigned ROWS = 9;
  localparam int unsigned COLS = 9;
  localparam int unsigned LEDS = ROWS * COLS;

  // Register offsets
  localparam logic [7:0] ADDR_ROW_FORCE_ON_UPPER = 8'h2F;
  localparam logic [7:0] ADDR_ROW_MASK_LOWER = 8'h30;
  localparam logic [7:0] ADDR_ROW_MASK_UPPER = 8'h31;
  localparam logic [7:0] ADDR_SLOPE_TIME_CONTROL = 8'h32;
  localparam logic [7:0] ADDR_MELODY_ON_COMP = 8'h33;
  localparam logic [7:0] ADDR_SCAN_COLUMN_COUNT = 8'h36;
  localparam logic [7:0] ADDR_DUTY_FIRST = 8'h40;
  localparam logic [7:0] ADDR_DUTY_LAST = 8'h90;

  // Reset values
  localparam logic [2:0] RST_ROW_FORCE_ON_UPPER = 3'h0;
  localparam logic [5:0] RST_ROW_MASK_LOWER = 6'h00;
  localparam logic [2:0] RST_ROW_MASK_UPPER = 3'h0;
  localparam logic [4:0] RST_SLOPE_TIME_CONTROL = 5'h00;
  localparam logic [2:0] RST_MELODY_ON_COMP = 3'h3;
  localparam logic [3:0] RST_SCAN_COLUMN_COUNT = 4'h8;
  localparam logic [7:0] RST_DUTY = 8'h00;

  // Field positions in the slope time register
  localparam int unsigned FADE_OUT_DOUBLE_BIT = 4;
  localparam int unsigned OFF_EXT_LSB = 2;
  localparam int unsigned ON_EXT_LSB = 0;

  // Scan-count code that means every column; larger codes behave the same
  localparam logic [3:0] SCAN_ALL_CODE = 4'h8;

  // Scan slot timing in logic clocks
  localparam int unsigned SLOT_CLKS = 255;
  localparam int unsigned GAP_CLKS = 4;
  localparam logic [7:0] SLOT_LAST = 8'(SLOT_CLKS - 1);
  localparam logic [7:0] SLOT_ACTIVE_END = 8'(SLOT_CLKS - GAP_CLKS);

  // Melody on-time compensation step
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MELODY_STEP_NS = 1940;
  localparam int unsigned MELODY_STEP_CLKS =
    (MELODY_STEP_NS / CLK_PERIOD_NS) > 0 ? (MELODY_STEP_NS / CLK_PERIOD_NS) : 1;

  // Extension multiplier codes
  typedef enum logic [1:0] {
    EXT_X1 = 2'b00,
    EXT_QUARTER = 2'b01,
    EXT_HALF = 2'b10,
    EXT_X2 = 2'b11
  } lmsp_ext_t;

  typedef struct packed {
    logic fade_out_double;
    lmsp_ext_t off_phase_extension;
    lmsp_ext_t on_phase_extension;
  } lmsp_slope_ctl_t;

  typedef struct packed {
    logic [16:0] fade_in_time;
    logic [16:0] on_hold_time;
    logic [16:0] fade_out_time;
    logic [16:0] off_hold_time;
  } lmsp_phase_times_t;

endpackage

// ===== src/lmsp_slope_timer.sv
/*
  Derives the four slope phase durations from the base slope time and the slope control fields.
  Assumes the base slope time is already a cycle count chosen by the per-LED setting logic.
*/
`timescale 1ns/1ps
`default_nettype none

module lmsp_slope_timer (
  // Inputs
  input wire logic [15:0] base_slope_time,
  input wire lmsp_pkg::lmsp_slope_ctl_t slope_ctl,
  // Result
  output lmsp_pkg::lmsp_phase_times_t phase_times
);

  logic [16:0] base_ext;

  function automatic logic [16:0] scale(input logic [16:0] t, input lmsp_pkg::lmsp_ext_t code);
    logic [16:0] r;
    r = t;
    case (code)
      lmsp_pkg::EXT_X1: r = t;
      lmsp_pkg::EXT_QUARTER: r = t >> 2;
      lmsp_pkg::EXT_HALF: r = t >> 1;
      lmsp_pkg::EXT_X2: r = t << 1;
      default: r = t;
    endcase
    return r;
  endfunction

  assign base_ext = {1'b0, base_slope_time};

  always_comb begin
    phase_times.fade_in_time = base_ext;
    // Applies to firefly and PWM fade alike: fade-out is twice fade-in when fade_out_double is set, else equal to it
    phase_times.fade_out_time = slope_ctl.fade_out_double ? (base_ext << 1) : base_ext;
    phase_times.off_hold_time = scale(base_ext, slope_ctl.off_phase_extension);
    phase_times.on_hold_time = scale(base_ext, slope_ctl.on_phase_extension);
  end

endmodule

`default_nettype wire

// ===== src/lmsp_scan_pwm_control.sv
/*
  Register bank, row scan sequencer and per-LED PWM for the 9x9 LED matrix driver.
  Assumes a serial slave front end turns bus writes and reads into single-cycle strobes,
  and that matrix enable, PWM enables, column constant mode and the lower row force-on
  bits come from registers held elsewhere.

*/
`timescale 1ns/1ps
`default_nettype none

module lmsp_scan_pwm_control (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port from the serial slave
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Settings held outside this block
  input wire logic matrix_enable,
  input wire logic [5:0] row_force_on_lower,
  input wire logic [lmsp_pkg::COLS-1:0] column_constant_mode,
  input wire logic [lmsp_pkg::LEDS-1:0] led_pwm_enable,
  input wire logic [15:0] base_slope_time,
  // Matrix drive
  output logic [lmsp_pkg::ROWS-1:0] row_switch_on,
  output logic [lmsp_pkg::COLS-1:0] column_sink_on,
  output logic [3:0] scan_row,
  // Slope and melody timing
  output lmsp_pkg::lmsp_phase_times_t phase_times,
  output logic [7:0] melody_extra_clks
);

  // Register bank
  logic [2:0] row_force_on_upper_q, row_force_on_upper_d;
  logic [5:0] row_mask_lower_q, row_mask_lower_d;
  logic [2:0] row_mask_upper_q, row_mask_upper_d;
  lmsp_pkg::lmsp_slope_ctl_t slope_time_control_q, slope_time_control_d;
  logic [2:0] melody_on_compensation_q, melody_on_compensation_d;
  logic [3:0] scan_column_count_q, scan_column_count_d;
  logic [7:0] reg_rdata_q, reg_rdata_d;
  logic [7:0] duty_mem [lmsp_pkg::LEDS];
  logic duty_hit;
  logic [7:0] duty_index;

  assign duty_hit = (reg_addr >= lmsp_pkg::ADDR_DUTY_FIRST) &&
                    (reg_addr <= lmsp_pkg::ADDR_DUTY_LAST);
  assign duty_index = reg_addr - lmsp_pkg::ADDR_DUTY_FIRST;

  always_comb begin
    row_force_on_upper_d = row_force_on_upper_q;
    row_mask_lower_d = row_mask_lower_q;
    row_mask_upper_d = row_mask_upper_q;
    slope_time_control_d = slope_time_control_q;
    melody_on_compensation_d = melody_on_compensation_q;
    scan_column_count_d = scan_column_count_q;
    if (reg_wr) begin
      // Only the implemented bits are stored, the rest are dropped
      case (reg_addr)
        lmsp_pkg::ADDR_ROW_FORCE_ON_UPPER: row_force_on_upper_d = reg_wdata[2:0];
        lmsp_pkg::ADDR_ROW_MASK_LOWER: row_mask_lower_d = reg_wdata[5:0];
        lmsp_pkg::ADDR_ROW_MASK_UPPER: row_mask_upper_d = reg_wdata[2:0];
        lmsp_pkg::ADDR_SLOPE_TIME_CONTROL: slope_time_control_d = reg_wdata[4:0];
        lmsp_pkg::ADDR_MELODY_ON_COMP: melody_on_compensation_d = reg_wdata[2:0];
        lmsp_pkg::ADDR_SCAN_COLUMN_COUNT: scan_column_count_d = reg_wdata[3:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        lmsp_pkg::ADDR_ROW_FORCE_ON_UPPER: reg_rdata_d = {5'h00, row_force_on_upper_q};
        lmsp_pkg::ADDR_ROW_MASK_LOWER: reg_rdata_d = {2'h0, row_mask_lower_q};
        lmsp_pkg::ADDR_ROW_MASK_UPPER: reg_rdata_d = {5'h00, row_mask_upper_q};
        lmsp_pkg::ADDR_SLOPE_TIME_CONTROL: reg_rdata_d = {3'h0, slope_time_control_q};
        lmsp_pkg::ADDR_MELODY_ON_COMP: reg_rdata_d = {5'h00, melody_on_compensation_q};
        lmsp_pkg::ADDR_SCAN_COLUMN_COUNT: reg_rdata_d = {4'h0, scan_column_count_q};
        default: reg_rdata_d = duty_hit ? duty_mem[duty_index[6:0]] : 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      row_force_on_upper_q <= lmsp_pkg::RST_ROW_FORCE_ON_UPPER;
      row_mask_lower_q <= lmsp_pkg::RST_ROW_MASK_LOWER;
      row_mask_upper_q <= lmsp_pkg::RST_ROW_MASK_UPPER;
      slope_time_control_q <= lmsp_pkg::RST_SLOPE_TIME_CONTROL;
      melody_on_compensation_q <= lmsp_pkg::RST_MELODY_ON_COMP;
      scan_column_count_q <= lmsp_pkg::RST_SCAN_COLUMN_COUNT;
      reg_rdata_q <= 8'h00;
    end else begin
      row_force_on_upper_q <= row_force_on_upper_d;
      row_mask_lower_q <= row_mask_lower_d;
      row_mask_upper_q <= row_mask_upper_d;
      slope_time_control_q <= slope_time_control_d;
      melody_on_compensation_q <= melody_on_compensation_d;
      scan_column_count_q <= scan_column_count_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // Duty storage: a plain array, written in place to avoid an 81-word next-state copy
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < lmsp_pkg::LEDS; i++) begin
        duty_mem[i] <= lmsp_pkg::RST_DUTY;
      end
    end else if (reg_wr && duty_hit) begin
      duty_mem[duty_index[6:0]] <= reg_wdata;
    end
  end

  // Scan sequencer
  logic [7:0] slot_cnt_q, slot_cnt_d;
  logic [3:0] scan_row_q, scan_row_d;
  logic [7:0] pwm_cnt_q, pwm_cnt_d;
  logic [3:0] last_row;
  logic slot_active;

  // Codes above the all-columns code clamp to it
  assign last_row = (scan_column_count_q >= lmsp_pkg::SCAN_ALL_CODE) ?
                    lmsp_pkg::SCAN_ALL_CODE : scan_column_count_q;
  assign slot_active = slot_cnt_q < lmsp_pkg::SLOT_ACTIVE_END;

  always_comb begin
    slot_cnt_d = slot_cnt_q + 8'h01;
    scan_row_d = scan_row_q;
    // Free-running 8-bit count so that a duty of N is on for N of 256 clocks
    pwm_cnt_d = pwm_cnt_q + 8'h01;
    if (!matrix_enable) begin
      slot_cnt_d = 8'h00;
      scan_row_d = 4'h0;
    end else if (slot_cnt_q == lmsp_pkg::SLOT_LAST) begin
      slot_cnt_d = 8'h00;
      // A shrunk count takes effect at the next slot boundary
      scan_row_d = (scan_row_q >= last_row) ? 4'h0 : scan_row_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slot_cnt_q <= 8'h00;
      scan_row_q <= 4'h0;
      pwm_cnt_q <= 8'h00;
    end else begin
      slot_cnt_q <= slot_cnt_d;
      scan_row_q <= scan_row_d;
      pwm_cnt_q <= pwm_cnt_d;
    end
  end

  // Matrix drive
  logic [lmsp_pkg::ROWS-1:0] row_force, row_mask, row_on_d, row_on_q;
  logic [lmsp_pkg::COLS-1:0] col_on_d, col_on_q;
  logic [6:0] led_base;

  assign row_force = {row_force_on_upper_q, row_force_on_lower};
  assign row_mask = {row_mask_upper_q, row_mask_lower_q};
  assign led_base = 7'(scan_row_q * lmsp_pkg::COLS);

  for (genvar r = 0; r < lmsp_pkg::ROWS; r++) begin : g_row
    always_comb begin
      if (!matrix_enable || row_mask[r]) begin
        row_on_d[r] = 1'b0;
      end else if (row_force[r]) begin
        row_on_d[r] = 1'b1;
      end else begin
        row_on_d[r] = slot_active && (scan_row_q == 4'(r));
      end
    end
  end

  for (genvar c = 0; c < lmsp_pkg::COLS; c++) begin : g_col
    logic [6:0] idx;
    logic pwm_on;
    assign idx = led_base + 7'(c);
    // Duty is ignored unless the LED's PWM enable is set
    assign pwm_on = led_pwm_enable[idx] ? (pwm_cnt_q < duty_mem[idx]) : 1'b1;
    always_comb begin
      if (!matrix_enable) begin
        col_on_d[c] = 1'b0;
      end else if (column_constant_mode[c]) begin
        col_on_d[c] = 1'b1;
      end else if (row_mask[scan_row_q]) begin
        col_on_d[c] = 1'b0;
      end else if (row_force[scan_row_q]) begin
        col_on_d[c] = 1'b1;
      end else begin
        col_on_d[c] = slot_active && pwm_on;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      row_on_q <= '0;
      col_on_q <= '0;
    end else begin
      row_on_q <= row_on_d;
      col_on_q <= col_on_d;
    end
  end

  // Slope and melody timing
  lmsp_pkg::lmsp_phase_times_t phase_d, phase_q;
  logic [7:0] melody_d, melody_q;

  lmsp_slope_timer u_slope_timer (
    .base_slope_time(base_slope_time),
    .slope_ctl(slope_time_control_q),
    .phase_times(phase_d)
  );

  assign melody_d = 8'(melody_on_compensation_q * lmsp_pkg::MELODY_STEP_CLKS);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= '0;
      melody_q <= 8'h00;
    end else begin
      phase_q <= phase_d;
      melody_q <= melody_d;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign row_switch_on = row_on_q;
  assign column_sink_on = col_on_q;
  assign scan_row = scan_row_q;
  assign phase_times = phase_q;
  assign melody_extra_clks = melody_q;

endmodule

`default_nettype wire

// ===== testbench/lmsp_scan_pwm_assertions.sv
/* Port assertions for the LED matrix scan and PWM block.
   Assumes the bind below; shadows only the registers the outputs depend on. */
`timescale 1ns/1ps
`default_nettype none
module lmsp_scan_pwm_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register writes and settings
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic matrix_enable,
  input wire logic [5:0] row_force_on_lower,
  input wire logic [15:0] base_slope_time,
  // Outputs
  input wire logic [8:0] row_switch_on,
  input wire logic [8:0] column_sink_on,
  input wire logic [3:0] scan_row,
  input wire lmsp_pkg::lmsp_phase_times_t phase_times,
  input wire logic [7:0] melody_extra_clks
);
  logic [2:0] frc_q;
  logic [8:0] msk_q;
  logic [4:0] slp_q;
  logic [2:0] mel_q;
  lmsp_pkg::lmsp_phase_times_t ph_q;
  logic [16:0] bs;
  logic [8:0] frc_all;
  assign bs = {1'b0, base_slope_time};
  assign frc_all = {frc_q, row_force_on_lower};
  function automatic logic [16:0] scl(input logic [1:0] c, input logic [16:0] b);
    return c == 2'h1 ? b >> 2 : c == 2'h2 ? b >> 1 : c == 2'h3 ? b << 1 : b;
  endfunction
  // Shadows load on the same edge as the block's bank, so expected timing lines up
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {frc_q, msk_q, slp_q, ph_q} <= '0;
      mel_q <= 3'h3;
    end else begin
      if (reg_wr && reg_addr == 8'h2F) frc_q <= reg_wdata[2:0];
      if (reg_wr && reg_addr == 8'h30) msk_q[5:0] <= reg_wdata[5:0];
      if (reg_wr && reg_addr == 8'h31) msk_q[8:6] <= reg_wdata[2:0];
      if (reg_wr && reg_addr == 8'h32) slp_q <= reg_wdata[4:0];
      if (reg_wr && reg_addr == 8'h33) mel_q <= reg_wdata[2:0];
      ph_q <= {bs, scl(slp_q[1:0], bs), slp_q[4] ? bs << 1 : bs, scl(slp_q[3:2], bs)};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_fade_in_base: assert property (phase_times.fade_in_time == ph_q.fade_in_time)
    else $error("fade-in time does not follow base slope time");
  a_on_hold_scale: assert property (phase_times.on_hold_time == ph_q.on_hold_time)
    else $error("on-hold time scaled wrongly");
  a_fade_out_double: assert property (phase_times.fade_out_time == ph_q.fade_out_time)
    else $error("fade-out time doubling wrong");
  a_off_hold_scale: assert property (phase_times.off_hold_time == ph_q.off_hold_time)
    else $error("off-phase time scaled wrongly");
  a_melody_steps: assert property (!$past(rst) |->
    melody_extra_clks == {5'h0, $past(mel_q)} * 8'h13) else $error("melody compensation wrong");
  a_mask_forces_off: assert property (!$past(rst) |->
    (row_switch_on & $past(msk_q)) == 9'h000) else $error("masked row switched on");
  a_force_turns_on: assert property (!$past(rst) && $past(matrix_enable) |->
    (~row_switch_on & ~$past(msk_q) & $past(frc_all)) == 9'h000) else $error("forced row off");
  a_disable_blanks: assert property (!matrix_enable |=>
    row_switch_on == 9'h000 && column_sink_on == 9'h000) else $error("drive while disabled");
  a_scan_ascends: assert property ($changed(scan_row) |-> scan_row == 4'h0 ||
    (scan_row == $past(scan_row) + 4'h1 && scan_row < 4'h9)) else $error("scan order wrong");
  a_slot_holds: assert property ($changed(scan_row) |=> $stable(scan_row) [*8])
    else $error("scan slot too short");
endmodule
bind lmsp_scan_pwm_control lmsp_scan_pwm_assertions u_chk (.sys_clk, .rst, .reg_wr, .reg_addr,
  .reg_wdata, .matrix_enable, .row_force_on_lower, .base_slope_time, .row_switch_on,
  .column_sink_on, .scan_row, .phase_times, .melody_extra_clks);
`default_nettype wire

// ===== testbench/lmsp_host_model.sv
/* Host model issuing byte writes and reads on the block's register strobes.
   Assumes one request per call; signals change only just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module lmsp_host_model (
  // Clock
  input wire logic sys_clk,
  // Requests toward the block
  output var logic reg_wr,
  output var logic reg_rd,
  output var logic [7:0] reg_addr,
  output var logic [7:0] reg_wdata,
  // Read data back
  input wire logic [7:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // Address and data flip once released, so a late capture shows up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
/* Self-checking bench for the LED matrix scan and PWM block.
   Assumes the host model drives the register strobes and the checker binds itself. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic matrix_enable = 1'b0;
  logic [5:0] row_force_on_lower = 6'h00;
  logic [80:0] led_pwm_enable = 81'h0;
  logic [8:0] column_constant_mode = 9'h000;
  logic [15:0] base_slope_time = 16'h1235;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, melody_extra_clks, d;
  logic [8:0] row_switch_on, column_sink_on;
  logic [3:0] scan_row;
  lmsp_pkg::lmsp_phase_times_t phase_times;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int n, cnt;
  logic [7:0] ra [9] = '{8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h36, 8'h40, 8'h90, 8'h37};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h08, 8'h00, 8'h00, 8'h00};
  logic [7:0] fv [9] = '{8'h07, 8'h3F, 8'h07, 8'h1F, 8'h07, 8'h0F, 8'hFF, 8'hFF, 8'h00};
  logic [7:0] dv [4] = '{8'h00, 8'h80, 8'hFF, 8'h00};
  int lo [4] = '{8'h00, 8'h7B, 8'hF9, 8'hF9};
  int hi [4] = '{8'h00, 8'h80, 8'hFB, 8'hFC};
  always #50 sys_clk = ~sys_clk;
  lmsp_host_model u_host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  lmsp_scan_pwm_control u_dut (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .matrix_enable, .row_force_on_lower, .column_constant_mode,
    .led_pwm_enable, .base_slope_time, .row_switch_on, .column_sink_on, .scan_row,
    .phase_times, .melody_extra_clks);
  task automatic chk(input string nm, input logic [67:0] s, input logic [67:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    chk("reg_rdata", d, e);
  endtask
  function automatic logic [16:0] mul_ext(input logic [1:0] c, input logic [16:0] b);
    return c == 2'h1 ? b >> 2 : c == 2'h2 ? b >> 1 : c == 2'h3 ? b << 1 : b;
  endfunction
  function automatic logic [67:0] exp_ph(input logic [4:0] c);
    logic [16:0] b;
    b = {1'b0, base_slope_time};
    return {b, mul_ext(c[1:0], b), c[4] ? b << 1 : b, mul_ext(c[3:2], b)};
  endfunction
  // Bounded wait for the scanned row to move; n is the slot length in clocks
  task automatic wait_chg(output int k);
    logic [3:0] s;
    s = scan_row;
    k = 0;
    while (scan_row === s && k < 10'h258) begin
      @(negedge sys_clk);
      k++;
    end
  endtask
  task automatic scan_run(input logic [7:0] code, input logic [3:0] top);
    logic [3:0] m;
    m = 4'h0;
    u_host.wr(8'h36, code);
    // A new count only lands at a slot boundary, so let the old pass finish
    repeat (10) wait_chg(n);
    for (int i = 0; i < 10; i++) begin
      wait_chg(n);
      chk("slot_clks", n, 9'h0FF);
      if (scan_row > m) m = scan_row;
    end
    chk("scan_row_max", m, top);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 16'h7530) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (ra[i]) rdc(ra[i], rv[i]);
    foreach (ra[i]) u_host.wr(ra[i], 8'hFF);
    foreach (ra[i]) rdc(ra[i], fv[i]);
    for (int c = 0; c < 32; c++) begin
      u_host.wr(8'h32, 8'(c));
      repeat (2) @(negedge sys_clk);
      chk("phase_times", phase_times, exp_ph(5'(c)));
    end
    for (int c = 0; c < 8; c++) begin
      u_host.wr(8'h33, 8'(c));
      repeat (2) @(negedge sys_clk);
      chk("melody_extra_clks", melody_extra_clks, c * 32'h13);
    end
    @(posedge sys_clk);
    matrix_enable <= 1'b1;
    row_force_on_lower <= 6'h01;
    column_constant_mode <= 9'h100;
    u_host.wr(8'h30, 8'h3E);
    u_host.wr(8'h2F, 8'h07);
    u_host.wr(8'h31, 8'h02);
    repeat (2) @(negedge sys_clk);
    chk("row_switch_on", row_switch_on, 9'h141);
    chk("column_sink_on", column_sink_on[8], 1'b1);
    for (int i = 0; i < 3; i++) u_host.wr(ra[i], 8'h00);
    row_force_on_lower <= 6'h00;
    column_constant_mode <= 9'h000;
    repeat (2) @(negedge sys_clk);
    chk("row_one_hot", $onehot0(row_switch_on), 1'b1);
    scan_run(8'h0F, 4'h8);
    scan_run(8'h01, 4'h1);
    // Count lit clocks of the first LED over one whole slot of its row
    for (int i = 0; i < 4; i++) begin
      u_host.wr(8'h40, dv[i]);
      led_pwm_enable[0] <= (i < 3);
      do wait_chg(n); while (scan_row !== 4'h0);
      cnt = 0;
      repeat (9'h0FF) begin
        @(negedge sys_clk);
        cnt += int'(row_switch_on[0] & column_sink_on[0]);
      end
      chk("lit_clks", cnt >= lo[i] && cnt <= hi[i], 1'b1);
    end
    wait_chg(n);
    repeat (8'h14) @(posedge sys_clk);
    matrix_enable <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("row_switch_on", row_switch_on, 9'h000);
    chk("column_sink_on", column_sink_on, 9'h000);
    chk("scan_row", scan_row, 4'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
